// *** core/pmm_cur_path.sv ***
// Current conversion path: offset, gain, bias, clamp and blanking
`timescale 1ns/1ps
module pmm_cur_path (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // Conversion in
  input  wire logic        valid_i,
  input  wire logic        offset_i,
  input  wire logic [17:0] raw_i,
  // Trim
  input  wire logic [10:0] gain_i,
  input  wire logic [7:0]  cob_i,
  input  wire logic        blank_en_i,
  // Results
  output logic [15:0]      current_o,
  output logic [15:0]      accum_o,
  output logic             accum_valid_o
);

  typedef struct packed {
    logic [17:0] offset;
    logic [15:0] current;
    logic [15:0] accum;
    logic        accum_valid;
  } pmm_cur_state_t;

  pmm_cur_state_t q;
  pmm_cur_state_t d;

  logic signed [18:0] corr;
  logic signed [30:0] prod;
  logic signed [21:0] biased;
  logic        [15:0] sat;

  function automatic logic [15:0] blank(input logic [15:0] v, input logic en);
    if (!v[15] && v < pmm_pkg::CHG_BLANK_LSB) begin
      return 16'h0000;
    end
    if (en && v[15] && (16'h0000 - v) < pmm_pkg::DSG_BLANK_LSB) begin
      return 16'h0000;
    end
    return v;
  endfunction

  always_comb begin
    d      = q;
    corr   = $signed({raw_i[17], raw_i}) - $signed({q.offset[17], q.offset});
    prod   = 31'(corr * $signed({1'b0, gain_i}));
    biased = 22'($signed(prod[30:pmm_pkg::GAIN_FRAC])) + 22'($signed(cob_i));
    if (biased > 22'sd32767) begin
      sat = pmm_pkg::CUR_POS_SAT;
    end else if (biased < -22'sd32768) begin
      sat = pmm_pkg::CUR_NEG_SAT;
    end else begin
      sat = biased[15:0];
    end
    d.accum_valid = valid_i;
    if (valid_i) begin
      if (offset_i) begin
        d.offset = raw_i;
        d.accum  = blank(q.current, blank_en_i);
      end else begin
        d.current = sat;
        d.accum   = blank(sat, blank_en_i);
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign current_o     = q.current;
  assign accum_o       = q.accum;
  assign accum_valid_o = q.accum_valid;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  offset_hold_a: assert property (valid_i && offset_i |=> $stable(current_o))
    else $error("current changed on offset conversion");
  chg_blank_a: assert property (
      accum_valid_o && !accum_o[15] |-> accum_o == 16'h0000 || accum_o >= 16'h0040)
    else $error("small charge result accumulated");

endmodule // pmm_cur_path

// *** core/pmm_fault_timer.sv ***
// Qualification timer for one protection condition
`timescale 1ns/1ps
module pmm_fault_timer (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // Condition and delay
  input  wire logic        cond_i,
  input  wire logic [31:0] limit_i,
  output logic             trip_o
);

  typedef struct packed {
    logic [31:0] cnt;
    logic        trip;
  } pmm_tmr_state_t;

  pmm_tmr_state_t q;
  pmm_tmr_state_t d;

  always_comb begin
    d = q;
    if (!cond_i) begin
      d.cnt = '0;
    end else if (q.cnt != limit_i) begin
      d.cnt = q.cnt + 32'd1;
    end
    d.trip = cond_i && (q.cnt == limit_i);
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign trip_o = q.trip;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  tmr_restart_a: assert property (!cond_i |=> q.cnt == 32'd0 && !trip_o)
    else $error("timer did not restart");
  tmr_cause_a: assert property (trip_o |-> $past(cond_i) && $past(q.cnt) == limit_i)
    else $error("trip without full delay");
  tmr_trip_c: cover property (cond_i ##1 trip_o);

endmodule // pmm_fault_timer

// *** core/pmm_pkg.sv ***
// Shared constants and types of the pack protect-and-measure block
package pmm_pkg;

  // ----------------------------------------
  // Clock and time base
  // ----------------------------------------
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned MEAS_PERIOD_MS  = 440;
  localparam int unsigned MEAS_PERIOD_CYC = MEAS_PERIOD_MS * (CLK_HZ / 1000);
  localparam int unsigned CUR_CONV_MS     = 3520;
  localparam int unsigned CUR_PERIODS     = CUR_CONV_MS / MEAS_PERIOD_MS;
  localparam int unsigned AVG_WINDOW_MS   = 28160;
  localparam int unsigned AVG_SAMPLES     = AVG_WINDOW_MS / CUR_CONV_MS;
  localparam logic [2:0]  CUR_SLOT_LAST   = 3'(CUR_PERIODS - 1);
  localparam logic [2:0]  AVG_LAST        = 3'(AVG_SAMPLES - 1);

  // ----------------------------------------
  // Fault delays (plain defaults)
  // ----------------------------------------
  localparam int unsigned UVD_MS  = 100;
  localparam int unsigned OCD_MS  = 10;
  localparam int unsigned SCD_US  = 200;
  localparam int unsigned OVD_MS  = 1000;
  localparam int unsigned UVD_CYC = UVD_MS * (CLK_HZ / 1000);
  localparam int unsigned OCD_CYC = OCD_MS * (CLK_HZ / 1000);
  localparam int unsigned SCD_CYC = SCD_US * (CLK_HZ / 1_000_000);
  localparam int unsigned OVD_CYC = OVD_MS * (CLK_HZ / 1000);

  // Fault vector positions
  localparam int FLT_OV  = 0;
  localparam int FLT_UV  = 1;
  localparam int FLT_COC = 2;
  localparam int FLT_DOC = 3;
  localparam int FLT_SC  = 4;
  localparam int FLT_N   = 5;

  // ----------------------------------------
  // Conversion formats
  // ----------------------------------------
  localparam int          ADC_W         = 18;
  localparam logic signed [17:0] VOLT_RAW_MAX = 18'sh003ff;
  localparam logic signed [17:0] VOLT_RAW_MIN = -18'sh00400;
  localparam logic [15:0] VOLT_SAT      = 16'h7fe0;
  localparam logic [15:0] VOLT_NEG_SAT  = 16'h8000;
  localparam logic [15:0] CUR_POS_SAT   = 16'h7fff;
  localparam logic [15:0] CUR_NEG_SAT   = 16'h8000;
  localparam int unsigned CUR_LSB_PV    = 1_562_500;
  localparam int unsigned CHG_BLANK_UV  = 100;
  localparam int unsigned DSG_BLANK_UV  = 25;
  localparam logic [15:0] CHG_BLANK_LSB = 16'(CHG_BLANK_UV * 1_000_000 / CUR_LSB_PV);
  localparam logic [15:0] DSG_BLANK_LSB = 16'(DSG_BLANK_UV * 1_000_000 / CUR_LSB_PV);
  localparam int          GAIN_FRAC     = 10;
  localparam logic [9:0]  OFS_LAST      = 10'h3ff;

  // Register map and reset values
  localparam logic [7:0]  ADDR_FGAIN_HI = 8'hb0;
  localparam logic [7:0]  ADDR_FGAIN_LO = 8'hb1;
  localparam logic [7:0]  COB_RESET     = 8'h00;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {CH_CELL_LO, CH_CELL_HI, CH_TEMP, CH_CURRENT, CH_OFFSET} pmm_chan_t;
  typedef enum logic [2:0] {SEQ_IDLE, SEQ_CELL_LO, SEQ_CELL_HI, SEQ_TEMP, SEQ_CUR} pmm_seq_t;

  typedef struct packed {
    logic cell_lo_uv;
    logic cell_hi_uv;
    logic cell_ov;
    logic cells_below_ce;
    logic charger;
    logic pack_low;
    logic charge_overcurrent;
    logic discharge_overcurrent;
    logic sc;
    logic dsg_release;
  } pmm_cmp_t;

  typedef struct packed {
    logic [15:0] cell_lo;
    logic [15:0] cell_hi;
    logic [15:0] temp;
    logic [15:0] current;
    logic [15:0] avg_current;
  } pmm_result_t;

  typedef struct packed {
    logic charge_gate_out;
    logic discharge_gate_out;
    logic recovery_en;
    logic pack_pulldown_en;
    logic pack_pullup_en;
    logic sleep;
  } pmm_drive_t;

endpackage

// *** core/pmm_protect_measure.sv ***
// Protection qualifier, gate drive and measurement scheduler for a two-cell pack
// What this block does
// - Cell under undervoltage longer than its delay turns both gates off.
// - Qualified undervoltage also enters sleep when the sleep enable bit is set.
// - Undervoltage with charger and low cells enables recovery charge; gates wait.
// - Lasting charge overcurrent turns both gates off, pulls pack down until low.
// - Lasting discharge overcurrent turns discharge off, pulls pack up until high.
// - Lasting short circuit turns discharge off, pulls pack up until high.
// - Charge gate on only without overvoltage, undervoltage, charge overcurrent, disable.
// - Discharge gate on only without undervoltage, overcurrents, short, disable.
// - Both cells converted every measurement period outside sleep, lower then upper.
// - Cell results two's complement, over-range stored as saturation code.
// - Temperature result refreshed every measurement period outside sleep.
// - Current result is sense voltage in two's complement.
// - Current result refreshed at end of each current conversion cycle.
// - Current clamps to positive and negative saturation codes.
// - Average current is mean of last eight results, once per window.
// - Every 1024th conversion measures offset, used for following 1023.
// - Offset conversion keeps previous current and accumulates it again.
// - Signed bias added to each offset-corrected, gain-scaled conversion, new value next conversion.
// - Bias is volatile two's complement, zero after power-on.
// - Small charge accumulation samples always blanked; small discharge ones when enabled.
// - Gain trim is 11 bits, zero to under two in 2^-10 steps.
// - Factory gain copy readable at two bytes, unused in calculation.
// - Lasting overvoltage drives charge gate low, discharge stays on.
`timescale 1ns/1ps
module pmm_protect_measure #(
  parameter int unsigned MEAS_PERIOD_CYC = pmm_pkg::MEAS_PERIOD_CYC,
  parameter int unsigned UVD_CYC         = pmm_pkg::UVD_CYC,
  parameter int unsigned OCD_CYC         = pmm_pkg::OCD_CYC,
  parameter int unsigned SCD_CYC         = pmm_pkg::SCD_CYC,
  parameter int unsigned OVD_CYC         = pmm_pkg::OVD_CYC
) (
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                arst_n_i,
  // Analog comparator levels
  input  wire pmm_pkg::pmm_cmp_t   cmp_i,
  // Control bits
  input  wire logic                undervoltage_sleep_enable_i,
  input  wire logic                charge_drive_disable_i,
  input  wire logic                discharge_drive_disable_i,
  input  wire logic                discharge_blank_enable_i,
  // Trim and bias
  input  wire logic [10:0]         current_gain_trim_i,
  input  wire logic [15:0]         factory_gain_copy_i,
  input  wire logic                cob_wr_i,
  input  wire logic [7:0]          cob_wdata_i,
  // Byte read port
  input  wire logic [7:0]          reg_addr_i,
  output logic [7:0]               reg_rdata_o,
  output logic [7:0]               current_offset_bias_reg_o,
  // Converter handshake
  output logic                     adc_req_o,
  output pmm_pkg::pmm_chan_t       adc_ch_o,
  input  wire logic                adc_ack_i,
  input  wire logic [17:0]         adc_data_i,
  // Results
  output pmm_pkg::pmm_result_t     result_o,
  output logic [15:0]              accum_sample_o,
  output logic                     accum_valid_o,
  // Gate drive and test currents
  output pmm_pkg::pmm_drive_t      drive_o
);

  typedef struct packed {
    pmm_pkg::pmm_cmp_t   s1;
    pmm_pkg::pmm_cmp_t   s2;
    pmm_pkg::pmm_cmp_t   s3;
    pmm_pkg::pmm_cmp_t   filt;
    logic [4:0]          flt;
    logic                sleep;
    pmm_pkg::pmm_drive_t drv;
    logic [31:0]         period_cnt;
    logic [2:0]          per_idx;
    logic                do_cur;
    logic [9:0]          ofs_cnt;
    pmm_pkg::pmm_seq_t   seq;
    logic [15:0]         cell_lo;
    logic [15:0]         cell_hi;
    logic [15:0]         temp;
    logic [18:0]         avg_sum;
    logic [2:0]          avg_cnt;
    logic [15:0]         avg;
    logic [7:0]          current_offset_bias;
    logic [7:0]          rdata;
  } pmm_state_t;

  pmm_state_t q;
  pmm_state_t d;

  logic [pmm_pkg::FLT_N-1:0] cond;
  logic [pmm_pkg::FLT_N-1:0] rel;
  logic [pmm_pkg::FLT_N-1:0] trip;
  logic [31:0]               lim [pmm_pkg::FLT_N];
  logic                      tick;
  logic                      cur_valid;
  logic [15:0]               cur_val;
  logic [18:0]               sum_next;

  function automatic logic [15:0] volt_fmt(input logic [17:0] raw);
    if ($signed(raw) > pmm_pkg::VOLT_RAW_MAX) begin
      return pmm_pkg::VOLT_SAT;
    end
    if ($signed(raw) < pmm_pkg::VOLT_RAW_MIN) begin
      return pmm_pkg::VOLT_NEG_SAT;
    end
    return {raw[10:0], 5'h00};
  endfunction

  // ----------------------------------------
  // Fault qualification
  // ----------------------------------------
  assign cond[pmm_pkg::FLT_OV]  = q.filt.cell_ov;
  assign cond[pmm_pkg::FLT_UV]  = q.filt.cell_lo_uv | q.filt.cell_hi_uv;
  assign cond[pmm_pkg::FLT_COC] = q.filt.charge_overcurrent;
  assign cond[pmm_pkg::FLT_DOC] = q.filt.discharge_overcurrent;
  assign cond[pmm_pkg::FLT_SC]  = q.filt.sc;

  assign rel[pmm_pkg::FLT_OV]  = q.filt.cells_below_ce | (q.filt.dsg_release & ~q.filt.cell_ov);
  assign rel[pmm_pkg::FLT_UV]  = ~cond[pmm_pkg::FLT_UV];
  assign rel[pmm_pkg::FLT_COC] = q.filt.pack_low;
  assign rel[pmm_pkg::FLT_DOC] = ~q.filt.pack_low;
  assign rel[pmm_pkg::FLT_SC]  = ~q.filt.pack_low;

  assign lim[pmm_pkg::FLT_OV]  = OVD_CYC;
  assign lim[pmm_pkg::FLT_UV]  = UVD_CYC;
  assign lim[pmm_pkg::FLT_COC] = OCD_CYC;
  assign lim[pmm_pkg::FLT_DOC] = OCD_CYC;
  assign lim[pmm_pkg::FLT_SC]  = SCD_CYC;

  for (genvar i = 0; i < pmm_pkg::FLT_N; i++) begin : g_tmr
    pmm_fault_timer u_tmr (
      .clk_i    (clk_i),
      .arst_n_i (arst_n_i),
      .cond_i   (cond[i]),
      .limit_i  (lim[i]),
      .trip_o   (trip[i])
    );
  end

  // ----------------------------------------
  // Current path
  // ----------------------------------------
  assign cur_valid = (q.seq == pmm_pkg::SEQ_CUR) && adc_ack_i;

  pmm_cur_path u_cur (
    .clk_i         (clk_i),
    .arst_n_i      (arst_n_i),
    .valid_i       (cur_valid),
    .offset_i      (q.ofs_cnt == pmm_pkg::OFS_LAST),
    .raw_i         (adc_data_i),
    .gain_i        (current_gain_trim_i),
    .cob_i         (q.current_offset_bias),
    .blank_en_i    (discharge_blank_enable_i),
    .current_o     (cur_val),
    .accum_o       (accum_sample_o),
    .accum_valid_o (accum_valid_o)
  );

  assign sum_next = q.avg_sum + {{3{cur_val[15]}}, cur_val};

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  assign tick = (q.period_cnt == MEAS_PERIOD_CYC - 1);

  always_comb begin
    d      = q;
    d.s1   = cmp_i;
    d.s2   = q.s1;
    d.s3   = q.s2;
    d.filt = pmm_pkg::pmm_cmp_t'((q.s2 & q.s3) | (q.filt & (q.s2 ^ q.s3)));

    // Set wins over release
    d.flt   = trip | (q.flt & ~rel);
    d.sleep = (trip[pmm_pkg::FLT_UV] & undervoltage_sleep_enable_i)
            | (q.sleep & ~q.filt.charger);

    d.drv.charge_gate_out    = ~q.flt[pmm_pkg::FLT_OV] & ~q.flt[pmm_pkg::FLT_UV]
                             & ~q.flt[pmm_pkg::FLT_COC] & ~charge_drive_disable_i;
    d.drv.discharge_gate_out = ~q.flt[pmm_pkg::FLT_UV] & ~q.flt[pmm_pkg::FLT_COC]
                             & ~q.flt[pmm_pkg::FLT_DOC] & ~q.flt[pmm_pkg::FLT_SC]
                             & ~discharge_drive_disable_i;
    d.drv.recovery_en        = q.flt[pmm_pkg::FLT_UV] & q.filt.charger
                             & q.filt.cells_below_ce;
    d.drv.pack_pulldown_en   = q.flt[pmm_pkg::FLT_COC];
    d.drv.pack_pullup_en     = q.flt[pmm_pkg::FLT_DOC] | q.flt[pmm_pkg::FLT_SC];
    d.drv.sleep              = q.sleep;

    if (cob_wr_i) begin
      d.current_offset_bias = cob_wdata_i;
    end

    if (reg_addr_i == pmm_pkg::ADDR_FGAIN_HI) begin
      d.rdata = factory_gain_copy_i[15:8];
    end else if (reg_addr_i == pmm_pkg::ADDR_FGAIN_LO) begin
      d.rdata = factory_gain_copy_i[7:0];
    end else begin
      d.rdata = 8'h00;
    end

    d.period_cnt = tick ? 32'h0 : q.period_cnt + 32'h1;

    case (q.seq)
      pmm_pkg::SEQ_IDLE: begin
        if (tick) begin
          d.per_idx = q.per_idx + 3'h1;
          d.do_cur  = (q.per_idx == pmm_pkg::CUR_SLOT_LAST);
          if (!q.sleep) begin
            d.seq = pmm_pkg::SEQ_CELL_LO;
          end
        end
      end
      pmm_pkg::SEQ_CELL_LO: begin
        if (adc_ack_i) begin
          d.cell_lo = volt_fmt(adc_data_i);
          d.seq     = pmm_pkg::SEQ_CELL_HI;
        end
      end
      pmm_pkg::SEQ_CELL_HI: begin
        if (adc_ack_i) begin
          d.cell_hi = volt_fmt(adc_data_i);
          d.seq     = pmm_pkg::SEQ_TEMP;
        end
      end
      pmm_pkg::SEQ_TEMP: begin
        if (adc_ack_i) begin
          d.temp = {adc_data_i[10:0], 5'h00};
          d.seq  = q.do_cur ? pmm_pkg::SEQ_CUR : pmm_pkg::SEQ_IDLE;
        end
      end
      pmm_pkg::SEQ_CUR: begin
        if (adc_ack_i) begin
          d.ofs_cnt = q.ofs_cnt + 10'h1;
          d.seq     = pmm_pkg::SEQ_IDLE;
        end
      end
      default: begin
        d.seq = pmm_pkg::SEQ_IDLE;
      end
    endcase

    // Average over eight current results, one update per window
    if (accum_valid_o) begin
      d.avg_cnt = q.avg_cnt + 3'h1;
      if (q.avg_cnt == pmm_pkg::AVG_LAST) begin
        d.avg     = sum_next[18:3];
        d.avg_sum = 19'h0;
      end else begin
        d.avg_sum = sum_next;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_comb begin
    case (q.seq)
      pmm_pkg::SEQ_CELL_LO: adc_ch_o = pmm_pkg::CH_CELL_LO;
      pmm_pkg::SEQ_CELL_HI: adc_ch_o = pmm_pkg::CH_CELL_HI;
      pmm_pkg::SEQ_TEMP:    adc_ch_o = pmm_pkg::CH_TEMP;
      pmm_pkg::SEQ_CUR: begin
        adc_ch_o = (q.ofs_cnt == pmm_pkg::OFS_LAST) ? pmm_pkg::CH_OFFSET
                                                    : pmm_pkg::CH_CURRENT;
      end
      default:              adc_ch_o = pmm_pkg::CH_CELL_LO;
    endcase
  end

  assign adc_req_o                  = (q.seq != pmm_pkg::SEQ_IDLE);
  assign reg_rdata_o                = q.rdata;
  assign current_offset_bias_reg_o  = q.current_offset_bias;
  assign drive_o                    = q.drv;
  assign result_o                   = '{cell_lo:     q.cell_lo,
                                        cell_hi:     q.cell_hi,
                                        temp:        q.temp,
                                        current:     cur_val,
                                        avg_current: q.avg};

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  uv_gates_off_a: assert property (
      q.flt[1] |=> !drive_o.charge_gate_out && !drive_o.discharge_gate_out)
    else $error("gate on during undervoltage");
  uv_sleep_en_a: assert property (
      $rose(q.sleep) |-> $past(undervoltage_sleep_enable_i) && $past(trip[1]))
    else $error("sleep without enable");
  sleep_no_conv_a: assert property (
      q.sleep && q.seq == pmm_pkg::SEQ_IDLE |=> !adc_req_o)
    else $error("conversion started in sleep");
  recovery_cause_a: assert property (drive_o.recovery_en |-> $past(q.flt[1]))
    else $error("recovery path without undervoltage");
  coc_pulldown_a: assert property (
      q.flt[2] |=> drive_o.pack_pulldown_en && !drive_o.charge_gate_out)
    else $error("charge overcurrent response missing");
  dsg_fault_a: assert property (
      (q.flt[3] || q.flt[4]) |=> drive_o.pack_pullup_en && !drive_o.discharge_gate_out)
    else $error("discharge fault response missing");
  chg_gate_a: assert property (
      drive_o.charge_gate_out
      |-> $past(!q.flt[0] && !q.flt[1] && !q.flt[2] && !charge_drive_disable_i))
    else $error("charge gate on in fault");
  dsg_gate_a: assert property (
      drive_o.discharge_gate_out |-> $past(q.flt[4:1] == 4'h0 && !discharge_drive_disable_i))
    else $error("discharge gate on in fault");
  ov_dsg_kept_a: assert property (
      q.flt == 5'h01 && !discharge_drive_disable_i |=> drive_o.discharge_gate_out)
    else $error("discharge off during overvoltage only");
  conv_start_a: assert property ($rose(adc_req_o) |-> $past(tick))
    else $error("conversion outside period tick");
  volt_fmt_a: assert property (
      result_o.cell_lo[4:0] == 5'h00 && result_o.cell_hi[4:0] == 5'h00)
    else $error("cell result off step");
  temp_update_a: assert property (
      $changed(result_o.temp) |-> $past(q.seq == pmm_pkg::SEQ_TEMP && adc_ack_i))
    else $error("temperature updated outside its slot");
  cur_update_a: assert property (
      $changed(result_o.current) |-> $past(cur_valid && adc_ch_o == pmm_pkg::CH_CURRENT))
    else $error("current updated outside a current conversion");
  offset_slot_a: assert property (
      adc_ch_o == pmm_pkg::CH_OFFSET |-> q.ofs_cnt == 10'h3ff && q.seq == pmm_pkg::SEQ_CUR)
    else $error("offset conversion out of turn");
  avg_update_a: assert property (
      $changed(q.avg) |-> $past(accum_valid_o && q.avg_cnt == 3'h7))
    else $error("average updated mid window");
  bias_write_a: assert property (
      cob_wr_i |=> current_offset_bias_reg_o == $past(cob_wdata_i))
    else $error("bias write lost");
  gain_read_a: assert property (
      reg_addr_i == pmm_pkg::ADDR_FGAIN_HI |=> reg_rdata_o == $past(factory_gain_copy_i[15:8]))
    else $error("factory gain high byte wrong");

  uv_trip_c: cover property ($rose(q.flt[1]) ##1 drive_o.sleep);
  offset_conv_c: cover property (cur_valid && adc_ch_o == pmm_pkg::CH_OFFSET);
  avg_update_c: cover property (accum_valid_o && q.avg_cnt == 3'h7);
  ov_only_c: cover property (q.flt == 5'h01 ##1 drive_o.discharge_gate_out);

endmodule // pmm_protect_measure

// *** test/pmm_adc_model.sv ***
// Converter model answering conversion requests per channel
`timescale 1ns/1ps
module pmm_adc_model (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               arst_n_i,
  // Request side
  input  wire logic               req_i,
  input  wire pmm_pkg::pmm_chan_t ch_i,
  // Answer side
  output logic                    ack_o,
  output logic [17:0]             data_o
);
  logic [2:0] cnt_q;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q  <= 3'h0;
      ack_o  <= 1'b0;
      data_o <= 18'h15555;
    end else begin
      ack_o  <= 1'b0;
      // Data is only meaningful with ack
      data_o <= ~data_o;
      if (req_i && !ack_o) begin
        cnt_q <= cnt_q + 3'h1;
        if (cnt_q == 3'h3) begin
          cnt_q <= 3'h0;
          ack_o <= 1'b1;
          case (ch_i)
            pmm_pkg::CH_CELL_LO: data_o <= 18'h00100;
            pmm_pkg::CH_CELL_HI: data_o <= 18'h01000;
            pmm_pkg::CH_TEMP:    data_o <= 18'h00020;
            pmm_pkg::CH_CURRENT: data_o <= 18'h00200;
            default:             data_o <= 18'h00000;
          endcase
        end
      end
    end
  end
endmodule // pmm_adc_model

// *** test/tb_pack_protect_and_measure.sv ***
// Self-checking bench of the protect-and-measure block
`timescale 1ns/1ps
module tb_pack_protect_and_measure;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  pmm_pkg::pmm_cmp_t cmp_i = '0;
  logic uvs_en = 1'b0, chg_dis = 1'b0, dsg_dis = 1'b0, blank_en = 1'b0, cob_wr = 1'b0;
  logic [7:0] addr = 8'h00, rdata, cob_q, cob_wd = 8'hf0;
  logic req, ack, acc_v;
  logic [17:0] adata;
  logic [15:0] acc, fgain = 16'ha53c;
  logic [10:0] gain = 11'h400;
  pmm_pkg::pmm_chan_t ch;
  pmm_pkg::pmm_result_t res;
  pmm_pkg::pmm_drive_t drv;
  int mismatches = 0, samples_checked = 0;
  always #5 clk_i = ~clk_i;
  pmm_protect_measure #(.MEAS_PERIOD_CYC(200), .UVD_CYC(20), .OCD_CYC(10), .SCD_CYC(5),
    .OVD_CYC(30)) dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .cmp_i(cmp_i),
    .undervoltage_sleep_enable_i(uvs_en), .charge_drive_disable_i(chg_dis),
    .discharge_drive_disable_i(dsg_dis), .discharge_blank_enable_i(blank_en),
    .current_gain_trim_i(gain), .factory_gain_copy_i(fgain), .cob_wr_i(cob_wr),
    .cob_wdata_i(cob_wd), .reg_addr_i(addr), .reg_rdata_o(rdata),
    .current_offset_bias_reg_o(cob_q), .adc_req_o(req), .adc_ch_o(ch), .adc_ack_i(ack),
    .adc_data_i(adata), .result_o(res), .accum_sample_o(acc), .accum_valid_o(acc_v),
    .drive_o(drv));
  pmm_adc_model adc (.clk_i(clk_i), .arst_n_i(arst_n_i), .req_i(req), .ch_i(ch),
    .ack_o(ack), .data_o(adata));
  task automatic chk(string name, logic [15:0] got, logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic do_reset();
    arst_n_i = 1'b0;
    cmp_i = '0;
    cyc(12);
    chk("drive_in_reset", 16'(drv), 16'h0000);
    chk("bias_in_reset", 16'(cob_q), 16'h0000);
    arst_n_i = 1'b1;
    cyc(3);
  endtask
  task automatic t_measure();
    cyc(260);
    chk("cell_lo", res.cell_lo, 16'h2000);
    chk("cell_hi_sat", res.cell_hi, 16'h7fe0);
    chk("temp", res.temp, 16'h0400);
  endtask
  task automatic t_regs();
    cob_wr = 1'b1;
    cyc(1);
    cob_wr = 1'b0;
    addr = 8'hb0;
    cyc(2);
    chk("bias", 16'(cob_q), 16'h00f0);
    chk("gain_hi", 16'(rdata), 16'h00a5);
    addr = 8'hb1;
    cyc(2);
    chk("gain_lo", 16'(rdata), 16'h003c);
    addr = 8'h37;
    cyc(2);
    chk("unmapped", 16'(rdata), 16'h0000);
  endtask
  task automatic t_uv();
    uvs_en = 1'b1;
    cmp_i.cell_lo_uv = 1'b1;
    cyc(15);
    cmp_i.cell_lo_uv = 1'b0;
    cyc(2);
    cmp_i.cell_lo_uv = 1'b1;
    cyc(15);
    chk("gates_gap", 16'({drv.charge_gate_out, drv.discharge_gate_out}), 16'h0003);
    cyc(20);
    chk("gates_uv", 16'({drv.charge_gate_out, drv.discharge_gate_out}), 16'h0000);
    chk("sleep_uv", 16'(drv.sleep), 16'h0001);
    uvs_en = 1'b0;
    cmp_i.charger = 1'b1;
    cmp_i.cells_below_ce = 1'b1;
    cyc(8);
    chk("recovery", 16'({drv.recovery_en, drv.sleep, drv.charge_gate_out}), 16'h0004);
  endtask
  task automatic t_doc();
    cmp_i.pack_low = 1'b1;
    cmp_i.discharge_overcurrent = 1'b1;
    cyc(25);
    chk("gates_doc", 16'({drv.charge_gate_out, drv.discharge_gate_out}), 16'h0002);
    chk("pullup_doc", 16'(drv.pack_pullup_en), 16'h0001);
    cmp_i.discharge_overcurrent = 1'b0;
    cmp_i.pack_low = 1'b0;
    cyc(8);
    chk("gates_rel", 16'({drv.charge_gate_out, drv.discharge_gate_out}), 16'h0003);
  endtask
  task automatic t_disable();
    chg_dis = 1'b1;
    cyc(3);
    chk("chg_dis", 16'({drv.charge_gate_out, drv.discharge_gate_out}), 16'h0001);
    chg_dis = 1'b0;
    dsg_dis = 1'b1;
    cyc(3);
    chk("dsg_dis", 16'({drv.charge_gate_out, drv.discharge_gate_out}), 16'h0002);
    dsg_dis = 1'b0;
  endtask
  task automatic t_faults();
    cmp_i.charge_overcurrent = 1'b1;
    cyc(25);
    chk("gates_coc", 16'({drv.charge_gate_out, drv.discharge_gate_out}), 16'h0000);
    chk("pulldown", 16'(drv.pack_pulldown_en), 16'h0001);
    cmp_i.charge_overcurrent = 1'b0;
    cmp_i.pack_low = 1'b1;
    cmp_i.cell_ov = 1'b1;
    cyc(45);
    chk("gates_ov", 16'({drv.charge_gate_out, drv.discharge_gate_out}), 16'h0001);
    cmp_i.cell_ov = 1'b0;
    cmp_i.pack_low = 1'b0;
    cmp_i.dsg_release = 1'b1;
    cyc(8);
    chk("gates_ov_rel", 16'({drv.charge_gate_out, drv.discharge_gate_out}), 16'h0003);
    cmp_i.dsg_release = 1'b0;
  endtask
  task automatic t_current();
    @(posedge acc_v);
    @(negedge clk_i);
    chk("current", res.current, 16'h01f0);
    chk("accum", acc, 16'h01f0);
    repeat (7) @(posedge acc_v);
    cyc(2);
    chk("avg", res.avg_current, 16'h01f0);
    gain = 11'h200;
    @(posedge acc_v);
    @(negedge clk_i);
    chk("gain_half", res.current, 16'h00f0);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    do_reset();
    t_measure();
    t_regs();
    t_disable();
    t_doc();
    t_faults();
    t_current();
    do_reset();
    t_uv();
    final_report();
  end
  initial begin
    #300000;
    mismatches++;
    final_report();
  end
endmodule // tb_pack_protect_and_measure
